//--- hw/fpc_pkg.sv
// Constants shared by the fast pulse counter preset and compare logic
package fpc_pkg;
  // ****************************************
  // Widths and limits
  // ****************************************
  localparam int          FPC_CNT_W      = 24;
  localparam int          FPC_DATA_W     = 32;
  localparam int          FPC_ADDR_W     = 8;
  localparam int          FPC_IRQ_W      = 4;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0]  FPC_OFF_CONFIG = 8'h00;
  localparam logic [7:0]  FPC_OFF_PRESET = 8'h04;
  localparam logic [7:0]  FPC_OFF_CMP    = 8'h08;
  localparam logic [7:0]  FPC_OFF_STATUS = 8'h0c;
  localparam logic [7:0]  FPC_OFF_COUNT  = 8'h10;
  localparam logic [7:0]  FPC_OFF_IRQST  = 8'h14;
  localparam logic [7:0]  FPC_OFF_IRQEN  = 8'h18;
  localparam logic [7:0]  FPC_OFF_IRQCLR = 8'h1c;
  // ****************************************
  // Config field positions
  // ****************************************
  localparam int          FPC_CFG_EN     = 0;
  localparam int          FPC_CFG_PRESRC = 1;
  localparam int          FPC_CFG_TWOPH  = 2;
  localparam int          FPC_CFG_DIRPIN = 3;
  localparam int          FPC_CFG_DOWN   = 4;
  localparam int          FPC_CFG_CYCLR  = 5;
  localparam int          FPC_CFG_MULT   = 8;
  localparam int          FPC_MULT_W     = 3;
  localparam int          FPC_CFG_W      = 11;
  localparam logic [10:0] FPC_CFG_RST    = 11'h100;
  localparam logic [2:0]  FPC_MULT_ONE   = 3'h1;
  localparam logic [2:0]  FPC_MULT_TWO   = 3'h2;
  localparam logic [2:0]  FPC_MULT_FOUR  = 3'h4;
  // ****************************************
  // Status codes and read fields
  // ****************************************
  localparam logic [7:0]  FPC_ST_OK      = 8'h00;
  localparam logic [7:0]  FPC_ST_MULT    = 8'h02;
  localparam logic [7:0]  FPC_ST_RANGE   = 8'h03;
  localparam logic [7:0]  FPC_ST_DISABLE = 8'h04;
  localparam int          FPC_ST_DONE    = 8;
  localparam int          FPC_CNT_CARRY  = 24;
  // ****************************************
  // Interrupt bits
  // ****************************************
  localparam int          FPC_IRQ_MATCH  = 0;
  localparam int          FPC_IRQ_CARRY  = 1;
  localparam int          FPC_IRQ_LOAD   = 2;
  localparam int          FPC_IRQ_ERR    = 3;
endpackage

//--- hw/fpc_rise_detect.sv
// Rising edge detector for a synchronous level input
module fpc_rise_detect
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Level in, pulse out
  input  wire logic level,
  output logic      rise
);
  logic levelPrev_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      levelPrev_q <= 1'b0;
    else
      levelPrev_q <= level;
  end

  assign rise = level & ~levelPrev_q;
endmodule // fpc_rise_detect

//--- hw/fpc_count_core.sv
// Count register with load, step and wrap detection
module fpc_count_core
#(
  parameter int CNT_W = 24
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Control
  input  wire logic             enable,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] loadValue,
  input  wire logic             step,
  input  wire logic             stepDown,
  // State
  output logic      [CNT_W-1:0] count,
  output logic                  wrapUp
);
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  wire              atMax = &count_q;

  assign wrapUp  = enable & ~load & step & ~stepDown & atMax;
  assign count_d = !enable ? '0 :
                   load    ? loadValue :
                   step    ? (stepDown ? count_q - 1'b1 : count_q + 1'b1) : count_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      count_q <= '0;
    else
      count_q <= count_d;
  end

  assign count = count_q;
endmodule // fpc_count_core

//--- hw/fpc_preset_compare.sv
// Preset, compare, status and register logic of the fast pulse counter
// ****************************************
// Operation
// ****************************************
// Operation
// - Program source: write request loads preset value
// - Pin source: pin rising edge loads preset; the code drops an edge that falls in the same cycle as a preset write
// - Pin source: program requests never load count
// - Carry output low during preset load
// - No preset load while counter disabled
// - Count reaching compare value raises task event
// - Done set after compare request executes
// - Error-free request reports status 00
// - Two-phase bad multiplier reports status 02
// - Out-of-range preset or compare reports 03
// - Preset while disabled reports status 04
// - Count forced zero while disabled
// - Carry clear input clears carry flag
// - Count readable together with carry flag
//
// Our own choices: the APB interface to the registers and the register offsets.
module fpc_preset_compare
  import fpc_pkg::*;
#(
  parameter int CNT_W = FPC_CNT_W
)
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [FPC_ADDR_W-1:0] paddr,
  input  wire logic [FPC_DATA_W-1:0] pwdata,
  output logic      [FPC_DATA_W-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Pulse front end
  input  wire logic                  countStep,
  input  wire logic                  countStepDown,
  input  wire logic                  presetPin,
  // Counter settings and state
  output logic                       counterEnable,
  output logic      [FPC_MULT_W-1:0] multSetting,
  output logic                       twoPhaseMode,
  output logic                       dirFromPin,
  output logic                       countDown,
  output logic                       carryFlag,
  output logic      [CNT_W-1:0]      currentCount,
  // Events
  output logic                       taskEvent,
  output logic                       irq
);
  // ****************************************
  // Elaboration checks
  // ****************************************
  if (CNT_W < 1 || CNT_W > FPC_CNT_CARRY)
  begin : gBadWidth
    $error("CNT_W must lie between 1 and 24");
  end

  function automatic logic hit(input logic [FPC_ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic outOfRange(input logic [FPC_DATA_W-1:0] v);
    outOfRange = |(v >> CNT_W);
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [FPC_CFG_W-1:0]  config_q;
  logic [CNT_W-1:0]      presetValue_q;
  logic [CNT_W-1:0]      compareValue_q;
  logic                  compareValid_q;
  logic [7:0]            statusCode_q;
  logic                  done_q;
  logic                  carry_q;
  logic                  matchPrev_q;
  logic [FPC_IRQ_W-1:0]  irqStat_q;
  logic [FPC_IRQ_W-1:0]  irqEn_q;
  logic [FPC_DATA_W-1:0] prdata_q;
  logic                  pready_q;
  logic                  pslverr_q;
  logic                  carryOut_q;
  logic                  taskEvent_q;
  logic                  irq_q;

  // ****************************************
  // Bus decode
  // ****************************************
  wire setupPhase = psel & ~penable;
  wire accessDone = psel & penable & pready_q;
  wire wrEn       = accessDone & pwrite & ~pslverr_q;
  wire mapped     = hit(paddr, FPC_OFF_CONFIG) | hit(paddr, FPC_OFF_PRESET) |
                    hit(paddr, FPC_OFF_CMP)    | hit(paddr, FPC_OFF_STATUS) |
                    hit(paddr, FPC_OFF_COUNT)  | hit(paddr, FPC_OFF_IRQST)  |
                    hit(paddr, FPC_OFF_IRQEN)  | hit(paddr, FPC_OFF_IRQCLR);
  wire wrConfig   = wrEn & hit(paddr, FPC_OFF_CONFIG);
  wire wrPreset   = wrEn & hit(paddr, FPC_OFF_PRESET);
  wire wrCompare  = wrEn & hit(paddr, FPC_OFF_CMP);
  wire wrIrqEn    = wrEn & hit(paddr, FPC_OFF_IRQEN);
  wire wrIrqClr   = wrEn & hit(paddr, FPC_OFF_IRQCLR);

  // ****************************************
  // Configuration
  // ****************************************
  wire                  enabled   = config_q[FPC_CFG_EN];
  wire                  pinSource = config_q[FPC_CFG_PRESRC];
  wire [FPC_MULT_W-1:0] newMult   = pwdata[FPC_CFG_MULT +: FPC_MULT_W];
  wire                  multLegal = (newMult == FPC_MULT_ONE) | (newMult == FPC_MULT_TWO) |
                                    (newMult == FPC_MULT_FOUR);
  wire                  multBad   = pwdata[FPC_CFG_TWOPH] & ~multLegal;
  wire                  cfgBad    = wrConfig & multBad;

  // ****************************************
  // Preset and compare requests
  // ****************************************
  wire valueBad    = outOfRange(pwdata);
  wire presetBad   = wrPreset & valueBad;
  wire presetOff   = wrPreset & ~valueBad & ~pinSource & ~enabled;
  wire progLoad    = wrPreset & ~valueBad & ~pinSource & enabled;
  wire pinRise;
  wire pinLoad     = pinRise & pinSource & enabled;
  wire pinOff      = pinRise & pinSource & ~enabled;
  wire loadNow     = progLoad | (pinLoad & ~wrPreset);
  wire [CNT_W-1:0] loadValue = progLoad ? pwdata[CNT_W-1:0] : presetValue_q;
  wire compareBad  = wrCompare & valueBad;
  wire compareOk   = wrCompare & ~valueBad;
  wire requestOk   = (wrConfig & ~multBad) | (wrPreset & ~valueBad & ~presetOff) |
                     compareOk | (pinLoad & ~wrEn);
  wire anyError    = cfgBad | presetBad | compareBad | presetOff | (pinOff & ~wrEn);
  wire [7:0] errorCode = cfgBad                  ? FPC_ST_MULT  :
                         (presetBad | compareBad) ? FPC_ST_RANGE :
                                                    FPC_ST_DISABLE;

  // ****************************************
  // Count and carry
  // ****************************************
  wire [CNT_W-1:0] count;
  wire             wrapUp;
  wire             carry_d = wrapUp | (carry_q & ~config_q[FPC_CFG_CYCLR]);

  fpc_rise_detect uPinEdge
  (
    .clk   (clk),
    .rst_b (rst_b),
    .level (presetPin),
    .rise  (pinRise)
  );

  fpc_count_core #(.CNT_W(CNT_W)) uCore
  (
    .clk       (clk),
    .rst_b     (rst_b),
    .enable    (enabled),
    .load      (loadNow),
    .loadValue (loadValue),
    .step      (countStep),
    .stepDown  (countStepDown),
    .count     (count),
    .wrapUp    (wrapUp)
  );

  // ****************************************
  // Compare match and interrupts
  // ****************************************
  wire match = enabled & compareValid_q & (count == compareValue_q);
  wire [FPC_IRQ_W-1:0] irqSet;
  assign irqSet[FPC_IRQ_MATCH] = match & ~matchPrev_q;
  assign irqSet[FPC_IRQ_CARRY] = wrapUp;
  assign irqSet[FPC_IRQ_LOAD]  = loadNow;
  assign irqSet[FPC_IRQ_ERR]   = anyError;
  wire [FPC_IRQ_W-1:0] irqClr    = wrIrqClr ? pwdata[FPC_IRQ_W-1:0] : '0;
  wire [FPC_IRQ_W-1:0] irqStat_d = (irqStat_q & ~irqClr) | irqSet;
  wire [FPC_IRQ_W-1:0] irqEn_d   = wrIrqEn ? pwdata[FPC_IRQ_W-1:0] : irqEn_q;

  // ****************************************
  // Read data
  // ****************************************
  wire [FPC_DATA_W-1:0] countWord = {{(FPC_DATA_W - FPC_CNT_CARRY - 1){1'b0}}, carry_q,
                                     {(FPC_CNT_CARRY - CNT_W){1'b0}}, count};
  wire [FPC_DATA_W-1:0] rdMux =
    hit(paddr, FPC_OFF_CONFIG) ? {{(FPC_DATA_W - FPC_CFG_W){1'b0}}, config_q} :
    hit(paddr, FPC_OFF_PRESET) ? {{(FPC_DATA_W - CNT_W){1'b0}}, presetValue_q} :
    hit(paddr, FPC_OFF_CMP)    ? {{(FPC_DATA_W - CNT_W){1'b0}}, compareValue_q} :
    hit(paddr, FPC_OFF_STATUS) ? {{(FPC_DATA_W - FPC_ST_DONE - 1){1'b0}}, done_q,
                                  statusCode_q} :
    hit(paddr, FPC_OFF_COUNT)  ? countWord :
    hit(paddr, FPC_OFF_IRQST)  ? {{(FPC_DATA_W - FPC_IRQ_W){1'b0}}, irqStat_q} :
    hit(paddr, FPC_OFF_IRQEN)  ? {{(FPC_DATA_W - FPC_IRQ_W){1'b0}}, irqEn_q} :
                                 '0;

  // ****************************************
  // Bus slave flops
  // ****************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end
    else
    begin
      pready_q  <= setupPhase;
      pslverr_q <= setupPhase & ~mapped;
      prdata_q  <= (setupPhase & ~pwrite) ? rdMux : prdata_q;
    end
  end

  // ****************************************
  // Control and value registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      config_q       <= FPC_CFG_RST;
      presetValue_q  <= '0;
      compareValue_q <= '0;
      compareValid_q <= 1'b0;
    end
    else
    begin
      if (wrConfig & ~multBad)
        config_q <= pwdata[FPC_CFG_W-1:0];
      if (wrPreset & ~valueBad)
        presetValue_q <= pwdata[CNT_W-1:0];
      if (compareOk)
      begin
        compareValue_q <= pwdata[CNT_W-1:0];
        compareValid_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Status, carry and events
  // ****************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      statusCode_q <= FPC_ST_OK;
      done_q       <= 1'b0;
      carry_q      <= 1'b0;
      carryOut_q   <= 1'b0;
      matchPrev_q  <= 1'b0;
      taskEvent_q  <= 1'b0;
      irqStat_q    <= '0;
      irqEn_q      <= '0;
      irq_q        <= 1'b0;
    end
    else
    begin
      if (anyError)
      begin
        statusCode_q <= errorCode;
        done_q       <= 1'b0;
      end
      else if (requestOk)
      begin
        statusCode_q <= FPC_ST_OK;
        done_q       <= 1'b1;
      end
      carry_q     <= carry_d;
      carryOut_q  <= carry_d & ~loadNow;
      matchPrev_q <= match;
      taskEvent_q <= match & ~matchPrev_q;
      irqStat_q   <= irqStat_d;
      irqEn_q     <= irqEn_d;
      irq_q       <= |(irqStat_d & irqEn_d);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign counterEnable = config_q[FPC_CFG_EN];
  assign multSetting   = config_q[FPC_CFG_MULT +: FPC_MULT_W];
  assign twoPhaseMode  = config_q[FPC_CFG_TWOPH];
  assign dirFromPin    = config_q[FPC_CFG_DIRPIN];
  assign countDown     = config_q[FPC_CFG_DOWN];
  assign carryFlag     = carryOut_q;
  assign currentCount  = count;
  assign taskEvent     = taskEvent_q;
  assign irq           = irq_q;

  // ****************************************
  // Assertions
  // ****************************************
  sequence apbSetupThenAccess;
    psel && !penable ##1 psel && penable;
  endsequence

  sequence matchRises;
    !match ##1 match;
  endsequence

  property readyOnAccess;
    @(posedge clk) disable iff (!rst_b) apbSetupThenAccess |-> pready;
  endproperty

  apb_ready_a: assert property (readyOnAccess)
    else $error("pready not high in access phase");
  zero_when_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    !counterEnable |=> currentCount == '0)
    else $error("count not zero while disabled");
  carry_low_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    loadNow |=> !carryFlag)
    else $error("carry flag high after preset load");
  prog_load_value_a: assert property (@(posedge clk) disable iff (!rst_b)
    wrPreset && !pinSource && enabled && !valueBad |=> currentCount == $past(pwdata[CNT_W-1:0]))
    else $error("program preset not loaded");
  pin_ignores_req_a: assert property (@(posedge clk) disable iff (!rst_b)
    wrPreset && pinSource && enabled && !pinRise && !countStep |=> $stable(currentCount))
    else $error("program request loaded in pin mode");
  pin_load_value_a: assert property (@(posedge clk) disable iff (!rst_b)
    pinRise && pinSource && enabled && !wrEn |=> currentCount == $past(presetValue_q))
    else $error("pin preset not loaded");
  no_load_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    loadNow |-> counterEnable)
    else $error("preset load while disabled");
  disabled_code_a: assert property (@(posedge clk) disable iff (!rst_b)
    presetOff |=> statusCode_q == FPC_ST_DISABLE && !done_q)
    else $error("status 04 missing");
  mult_code_a: assert property (@(posedge clk) disable iff (!rst_b)
    wrConfig && multBad |=> statusCode_q == FPC_ST_MULT && $stable(config_q))
    else $error("status 02 missing");
  range_code_a: assert property (@(posedge clk) disable iff (!rst_b)
    (wrPreset || wrCompare) && valueBad && !cfgBad |=> statusCode_q == FPC_ST_RANGE)
    else $error("status 03 missing");
  compare_done_a: assert property (@(posedge clk) disable iff (!rst_b)
    compareOk |=> done_q && statusCode_q == FPC_ST_OK)
    else $error("compare request not done");
  task_event_a: assert property (@(posedge clk) disable iff (!rst_b)
    matchRises |=> taskEvent ##1 !taskEvent)
    else $error("task event not a single pulse on match");
  carry_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
    wrapUp |=> carry_q ##1 (carry_q || $past(config_q[FPC_CFG_CYCLR])))
    else $error("carry not set on wrap");
  carry_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    config_q[FPC_CFG_CYCLR] && !wrapUp |=> !carry_q)
    else $error("carry not cleared");
endmodule // fpc_preset_compare

//--- sim/fpc_encoder_model.sv
// Pulse encoder and preset switch model driving the counter front end
module fpc_encoder_model
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Commands from the bench
  input  wire logic stepRun,
  input  wire logic slowMode,
  input  wire logic stepDownReq,
  input  wire logic pinReq,
  // Lines into the counter
  output logic      countStep,
  output logic      countStepDown,
  output logic      presetPin
);
  timeunit 1ns;
  timeprecision 100ps;

  logic phase_q;

  // ****************************************
  // Pulses every cycle, or every other cycle when slow
  // ****************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_q       <= 1'b0;
      countStep     <= 1'b0;
      countStepDown <= 1'b0;
      presetPin     <= 1'b0;
    end
    else
    begin
      phase_q       <= ~phase_q;
      countStep     <= stepRun & (~slowMode | phase_q);
      countStepDown <= stepDownReq;
      presetPin     <= pinReq;
    end
  end
endmodule // fpc_encoder_model

//--- sim/test_fast_counter_preset_compare.sv
// Self-checking bench for the fast pulse counter preset and compare block
module test_fast_counter_preset_compare
  import fpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int TIMEOUT_CYCLES = 5000;
  logic        clk = 1'b0, rst_b = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, countStep, countStepDown, presetPin;
  logic        stepRun = 1'b0, slowMode = 1'b0, pinReq = 1'b0, stepDown = 1'b0;
  logic        counterEnable, twoPhaseMode, dirFromPin, countDown, carryFlag, taskEvent, irq;
  logic [2:0]  multSetting;
  logic [23:0] currentCount;
  int          errCount = 0, checksDone = 0, cycles = 0;

  always #4 clk = ~clk;

  fpc_encoder_model encoder (.clk(clk), .rst_b(rst_b), .stepRun(stepRun), .slowMode(slowMode),
    .stepDownReq(stepDown), .pinReq(pinReq), .countStep(countStep),
    .countStepDown(countStepDown), .presetPin(presetPin));

  fpc_preset_compare dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .countStep(countStep), .countStepDown(countStepDown),
    .presetPin(presetPin), .counterEnable(counterEnable), .multSetting(multSetting),
    .twoPhaseMode(twoPhaseMode), .dirFromPin(dirFromPin), .countDown(countDown),
    .carryFlag(carryFlag), .currentCount(currentCount), .taskEvent(taskEvent), .irq(irq));

  // ****************************************
  // Checking and bus helpers
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      errCount++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic endOfTest;
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] mask,
                       input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(what, rd & mask, exp);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset_values;
    logic [31:0] rd;
    logic        err;
    rdchk("config", FPC_OFF_CONFIG, 32'hffffffff, {21'h0, FPC_CFG_RST});
    rdchk("status", FPC_OFF_STATUS, 32'hffffffff, 32'h0);
    rdchk("count", FPC_OFF_COUNT, 32'hffffffff, 32'h0);
    chk("multSetting", multSetting, FPC_MULT_ONE);
    apb(1'b0, 8'h40, 32'h0, rd, err);
    chk("unmapped err", err, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test_reset_values done");
  endtask

  task automatic test_program_preset;
    wr(FPC_OFF_CONFIG, 32'h100);
    wr(FPC_OFF_PRESET, 32'h123);
    rdchk("disabled status", FPC_OFF_STATUS, 32'h1ff, 32'h004);
    chk("disabled count", currentCount, 32'h0);
    wr(FPC_OFF_CONFIG, 32'h101);
    wr(FPC_OFF_PRESET, 32'h123);
    rdchk("load status", FPC_OFF_STATUS, 32'h1ff, 32'h100);
    chk("loaded count", currentCount, 32'h123);
    wr(FPC_OFF_PRESET, 32'h200);
    wr(FPC_OFF_PRESET, 32'h201);
    @(negedge clk);
    chk("second load", currentCount, 32'h201);
    wr(FPC_OFF_CONFIG, 32'h100);
    repeat (2) @(negedge clk);
    chk("cleared count", currentCount, 32'h0);
    $display("test_program_preset done");
  endtask

  task automatic test_range_errors;
    wr(FPC_OFF_CONFIG, 32'h101);
    wr(FPC_OFF_PRESET, 32'h0100_0000);
    rdchk("preset range", FPC_OFF_STATUS, 32'hff, 32'h03);
    chk("no load", currentCount, 32'h0);
    wr(FPC_OFF_PRESET, 32'h00ff_ffff);
    @(negedge clk);
    chk("max load", currentCount, 32'hff_ffff);
    wr(FPC_OFF_CMP, 32'h0100_0000);
    rdchk("compare range", FPC_OFF_STATUS, 32'hff, 32'h03);
    wr(FPC_OFF_CMP, 32'h00ff_ffff);
    rdchk("compare done", FPC_OFF_STATUS, 32'h1ff, 32'h100);
    $display("test_range_errors done");
  endtask

  task automatic test_mult_setting;
    logic [2:0] good [3] = '{3'h1, 3'h2, 3'h4};
    logic [2:0] bad [3] = '{3'h0, 3'h3, 3'h7};
    foreach (bad[i])
    begin
      wr(FPC_OFF_CONFIG, {21'h0, bad[i], 8'h05});
      rdchk("bad mult", FPC_OFF_STATUS, 32'hff, 32'h02);
      rdchk("config kept", FPC_OFF_CONFIG, 32'h7ff, 32'h101);
    end
    foreach (good[i])
    begin
      wr(FPC_OFF_CONFIG, {21'h0, good[i], 8'h05});
      @(negedge clk);
      chk("multSetting", multSetting, good[i]);
      chk("twoPhaseMode", twoPhaseMode, 32'h1);
    end
    wr(FPC_OFF_CONFIG, 32'h119);
    @(negedge clk);
    chk("dirFromPin", dirFromPin, 32'h1);
    chk("countDown", countDown, 32'h1);
    wr(FPC_OFF_CONFIG, 32'h101);
    $display("test_mult_setting done");
  endtask

  task automatic pin_pulse;
    pinReq <= 1'b1;
    repeat (4) @(posedge clk);
    pinReq <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic test_pin_preset;
    wr(FPC_OFF_CONFIG, 32'h103);
    wr(FPC_OFF_PRESET, 32'h55);
    rdchk("pin store", FPC_OFF_STATUS, 32'hff, 32'h00);
    chk("request ignored", currentCount, 32'hff_ffff);
    pin_pulse();
    chk("pin load", currentCount, 32'h55);
    rdchk("pin status", FPC_OFF_STATUS, 32'h1ff, 32'h100);
    wr(FPC_OFF_CONFIG, 32'h102);
    pin_pulse();
    chk("pin disabled", currentCount, 32'h0);
    rdchk("pin disabled", FPC_OFF_STATUS, 32'hff, 32'h04);
    $display("test_pin_preset done");
  endtask

  task automatic test_compare_carry;
    int ev;
    logic lowSeen;
    ev = 0;
    wr(FPC_OFF_CONFIG, 32'h101);
    wr(FPC_OFF_IRQCLR, 32'hf);
    wr(FPC_OFF_IRQEN, 32'h3);
    wr(FPC_OFF_PRESET, 32'hff_fffd);
    wr(FPC_OFF_CMP, 32'h1);
    slowMode <= 1'b1;
    stepRun  <= 1'b1;
    repeat (8)
    begin
      @(posedge clk);
      ev += (taskEvent === 1'b1);
    end
    stepRun <= 1'b0;
    repeat (6)
    begin
      @(posedge clk);
      ev += (taskEvent === 1'b1);
    end
    chk("task events", ev, 32'h1);
    chk("carryFlag set", carryFlag, 32'h1);
    rdchk("count read", FPC_OFF_COUNT, 32'hffffffff, 32'h0100_0001);
    rdchk("irq status", FPC_OFF_IRQST, 32'h3, 32'h3);
    chk("irq", irq, 32'h1);
    wr(FPC_OFF_IRQEN, 32'h0);
    repeat (2) @(negedge clk);
    chk("irq masked", irq, 32'h0);
    wr(FPC_OFF_IRQEN, 32'h3);
    wr(FPC_OFF_PRESET, 32'h10);
    @(negedge clk);
    lowSeen = (carryFlag === 1'b0);
    @(negedge clk);
    lowSeen |= (carryFlag === 1'b0);
    chk("carry low on load", lowSeen, 32'h1);
    repeat (2) @(negedge clk);
    chk("carry sticky", carryFlag, 32'h1);
    wr(FPC_OFF_CONFIG, 32'h121);
    repeat (2) @(negedge clk);
    chk("carry cleared", carryFlag, 32'h0);
    wr(FPC_OFF_CONFIG, 32'h101);
    // Two down steps from zero wrap below zero without carry
    wr(FPC_OFF_PRESET, 32'h0);
    stepDown <= 1'b1;
    stepRun  <= 1'b1;
    repeat (4) @(posedge clk);
    stepRun  <= 1'b0;
    stepDown <= 1'b0;
    repeat (2) @(negedge clk);
    chk("down count", currentCount, 32'hff_fffe);
    chk("down no carry", carryFlag, 32'h0);
    wr(FPC_OFF_IRQCLR, 32'hf);
    rdchk("irq cleared", FPC_OFF_IRQST, 32'hffffffff, 32'h0);
    rdchk("clear reads 0", FPC_OFF_IRQCLR, 32'hffffffff, 32'h0);
    chk("irq low", irq, 32'h0);
    $display("test_compare_carry done");
  endtask

  // ****************************************
  // Sequence and timeout
  // ****************************************
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES)
    begin
      errCount++;
      endOfTest();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    test_reset_values();
    test_program_preset();
    test_range_errors();
    test_mult_setting();
    test_pin_preset();
    test_compare_carry();
    endOfTest();
  end
endmodule // test_fast_counter_preset_compare
